/* src/fast_gate_a20_and_cpu_reset.v */
// fast gate-A20 and alternate cpu reset control port
`timescale 1ns/10ps
`default_nettype none
`include "fast_gate_regs.vh"
module fast_gate_a20_and_cpu_reset #(
  parameter DELAY_CYC = `FG_DELAY_CYC,
  parameter WIDTH_CYC = `FG_WIDTH_CYC
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_b,
  // host i/o bus
  input wire [15:0] i_io_addr,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire [7:0] i_io_wdata,
  output reg [7:0] o_io_rdata,
  output reg o_io_rdata_oe,
  // configuration
  input wire [7:0] i_kbd_reset_gate_cfg,
  input wire i_reset_polarity,
  input wire i_p17_open_drain,
  // keyboard controller side
  input wire i_kbc_gate_port_bit,
  input wire i_kbc_reset_n,
  input wire i_kbc_port_bit_seventeen,
  // outputs
  output reg o_alternate_gate_line,
  output reg o_fast_reset_pulse_n,
  output reg o_addr20_mask_out_n,
  output reg o_cpu_reset_out,
  output wire o_p17_out,
  output wire o_p17_oe_b
);
  localparam ST_IDLE = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_PULSE = 2'd2;
  localparam ST_DONE = 2'd3;

  reg rst_bit_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [11:0] cnt_r;
  reg [11:0] cnt_nxt;
  wire [11:0] delay_cyc = DELAY_CYC[11:0];
  wire [11:0] width_cyc = WIDTH_CYC[11:0];

  wire port_en = i_kbd_reset_gate_cfg[`FG_CFG_EN_BIT]; // RL1
  wire hit = (i_io_addr == `FG_PORT_ADDR) && port_en; // RL1 RL2
  wire wr_hit = hit && i_io_wr; // RL16
  wire [7:0] rd_val = (`FG_RSVD_VALUE & `FG_RSVD_MASK) |
    {6'h00, o_alternate_gate_line, rst_bit_r}; // RL3

  // register bits; reset equals 24h with both live bits clear
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rst_bit_r <= 1'b0; // RL7
      o_alternate_gate_line <= 1'b0; // RL6
    end else if (wr_hit) begin
      rst_bit_r <= i_io_wdata[`FG_BIT_RST];
      o_alternate_gate_line <= i_io_wdata[`FG_BIT_GATE]; // RL4
    end
  end

  // reads answer one cycle later; bus left undriven when disabled
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_io_rdata <= 8'h00;
      o_io_rdata_oe <= 1'b0;
    end else begin
      o_io_rdata_oe <= hit && i_io_rd; // RL16
      o_io_rdata <= (hit && i_io_rd) ? rd_val : 8'h00; // RL2 RL3
    end
  end

  // pulse sequencer: delay, then low pulse, then wait for bit 0 clear
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (wr_hit && i_io_wdata[`FG_BIT_RST] && !rst_bit_r) begin
          state_nxt = ST_DELAY; // RL8
          cnt_nxt = delay_cyc - 12'd1;
        end
      end
      ST_DELAY: begin
        if (cnt_r == 12'd0) begin
          state_nxt = ST_PULSE; // RL8 RL9 RL17
          cnt_nxt = width_cyc - 12'd1;
        end else begin
          cnt_nxt = cnt_r - 12'd1; // RL17
        end
      end
      ST_PULSE: begin
        if (cnt_r == 12'd0) begin
          state_nxt = ST_DONE;
        end else begin
          cnt_nxt = cnt_r - 12'd1; // RL17
        end
      end
      ST_DONE: begin
        if (!rst_bit_r) begin
          state_nxt = ST_IDLE; // RL10
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // outputs registered so the cpu pins never glitch
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_fast_reset_pulse_n <= 1'b1; // RL7
      o_addr20_mask_out_n <= 1'b0;
      o_cpu_reset_out <= 1'b1;
    end else begin
      o_fast_reset_pulse_n <= (state_nxt != ST_PULSE); // RL8
      o_addr20_mask_out_n <= i_kbc_gate_port_bit |
        o_alternate_gate_line; // RL5 RL14 RL15
      // low-active combined reset, inverted when polarity selects high
      o_cpu_reset_out <= (i_kbc_reset_n &
        (o_fast_reset_pulse_n | ~port_en)) ^ i_reset_polarity; // RL11
    end
  end

  kbc_port17_drive #(
    .PUSH_CYC(`FG_PUSH_HIGH_CYC)
  ) u_p17 (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_kbc_port_bit_seventeen(i_kbc_port_bit_seventeen),
    .i_open_drain(i_p17_open_drain),
    .o_p17_out(o_p17_out),
    .o_p17_oe_b(o_p17_oe_b)
  );
endmodule
`default_nettype wire

/* src/fast_gate_regs.vh */
// constants for the fast gate-A20 and alternate cpu reset port
// Operation
// RL1 - The control port is reachable only while bit 2 of the keyboard-reset/gate configuration register is one.
// RL2 - The control port is an 8-bit read/write register at I/O location 92h that resets to 24h.
// RL3 - Reserved bits read as fixed values: 7:6 as 00, 5 as 1, 4 and 3 as 0, 2 as 1.
// RL4 - Writing bit 1 sets the alternate gate line to the written value.
// RL5 - The address-20 mask output is low only when the keyboard gate bit and the alternate gate line are both low.
// RL6 - System reset drives the alternate gate line low.
// RL7 - System reset clears bit 0 and leaves the alternate reset pulse inactive high.
// RL8 - Writing a one to bit 0 gives one low reset pulse of at least 6 us after a delay of at least 14 us.
// RL9 - The shorter figures of 1 us width after 500 ns are also printed; the longer set is met, which covers both.
// RL10 - No further pulse is produced until bit 0 has gone back to zero by a host write or system reset.
// RL11 - When enabled, the pulse is ANDed with the keyboard reset and driven on the cpu reset output with configurable polarity.
// RL12 - In push mode port bit 17 drives low for zero, and for one drives high for a few clocks then releases to the pull-up.
// RL13 - In open-drain mode port bit 17 drives low for zero and tristates for one with no active high phase.
// RL14 - The keyboard controller port bit 21 is the software gate combined with the alternate gate line.
// RL15 - Two gate and reset sources exist: keyboard controller software and the fast control port.
// RL16 - While disabled, writes leave the port unchanged and reads do not drive the data bus.
// RL17 - Pulse delay and width are timed by a counter on the device clock, rounded up to meet the minimums.
`ifndef FAST_GATE_REGS_VH
`define FAST_GATE_REGS_VH

`define FG_PORT_ADDR 16'h0092
`define FG_PORT_RESET 8'h24
`define FG_CFG_EN_BIT 2
`define FG_BIT_RST 0
`define FG_BIT_GATE 1
`define FG_RSVD_MASK 8'hFC
`define FG_RSVD_VALUE 8'h24
`define FG_CLK_PERIOD_PS 8000
`define FG_DELAY_NS 14000
`define FG_WIDTH_NS 6000
`define FG_DELAY_CYC ((`FG_DELAY_NS * 1000 + `FG_CLK_PERIOD_PS - 1) / `FG_CLK_PERIOD_PS)
`define FG_WIDTH_CYC ((`FG_WIDTH_NS * 1000 + `FG_CLK_PERIOD_PS - 1) / `FG_CLK_PERIOD_PS)
`define FG_PUSH_HIGH_CYC 4

`endif

/* src/kbc_port17_drive.v */
// port bit 17 output driver with push and open-drain modes
`timescale 1ns/10ps
`default_nettype none
`include "fast_gate_regs.vh"
module kbc_port17_drive #(
  parameter PUSH_CYC = `FG_PUSH_HIGH_CYC
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_b,
  // port value and mode
  input wire i_kbc_port_bit_seventeen,
  input wire i_open_drain,
  // pin
  output reg o_p17_out,
  output wire o_p17_oe_b
);
  reg [7:0] boost_r;
  reg prev_r;
  wire [7:0] push_cyc = PUSH_CYC[7:0];

  // a short strong drive speeds the edge; the weak pull-up keeps the level
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      boost_r <= 8'h00;
      prev_r <= 1'b1;
      o_p17_out <= 1'b1;
    end else begin
      prev_r <= i_kbc_port_bit_seventeen;
      o_p17_out <= i_kbc_port_bit_seventeen;
      if (!i_kbc_port_bit_seventeen || i_open_drain) begin
        boost_r <= 8'h00; // RL13
      end else if (!prev_r) begin
        boost_r <= push_cyc; // RL12
      end else if (boost_r != 8'h00) begin
        boost_r <= boost_r - 8'h01; // RL12
      end
    end
  end

  assign o_p17_oe_b = ~(~o_p17_out | (boost_r != 8'h00)); // RL12 RL13
endmodule
`default_nettype wire

/* test/fast_gate_a20_and_cpu_reset_bench.sv */
// bench for the fast gate port
`timescale 1ns/10ps
`default_nettype none
module fast_gate_a20_and_cpu_reset_bench;
  logic clk = 0, rst_b = 0, pol = 0, od = 0, kg = 0, kr_b = 1, p17 = 0;
  logic [7:0] cfg = 8'h04, rd, q, wd;
  logic [15:0] a;
  logic w, r, e, oe, gl, pn_b, mk, cr, po, pe_b;
  int bad_count = 0, check_count = 0, cyc = 0, n;
  fast_gate_a20_and_cpu_reset #(.DELAY_CYC(4), .WIDTH_CYC(3)) uut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_io_addr(a), .i_io_wr(w),
    .i_io_rd(r), .i_io_wdata(wd), .o_io_rdata(rd), .o_io_rdata_oe(oe),
    .i_kbd_reset_gate_cfg(cfg), .i_reset_polarity(pol),
    .i_p17_open_drain(od), .i_kbc_gate_port_bit(kg), .i_kbc_reset_n(kr_b),
    .i_kbc_port_bit_seventeen(p17), .o_alternate_gate_line(gl),
    .o_fast_reset_pulse_n(pn_b), .o_addr20_mask_out_n(mk),
    .o_cpu_reset_out(cr), .o_p17_out(po), .o_p17_oe_b(pe_b));
  isa_host_model host (.i_clk_sys(clk), .i_rdata(rd), .i_oe(oe),
    .o_addr(a), .o_wr(w), .o_rd(r), .o_wdata(wd));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] s, x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 3000) begin
    bad_count++;
    finish_test;
  end
  task automatic t_gate;
    for (int i = 0; i < 4; i++) begin
      kg = i[1];
      host.io(1, 16'h0092, {6'h00, i[0], 1'h0}, q, e);
      host.io(0, 16'h0092, 8'h00, q, e);
      chk(q, 8'h24 | {i[0], 1'h0});
      chk(mk, i[0] | i[1]);
    end
  endtask
  task automatic pulse(input logic [7:0] d, output int m);
    host.io(1, 16'h0092, d, q, e);
    {n, m} = 0;
    while (pn_b !== 0 && n < 12) begin @(negedge clk); n++; end
    while (pn_b === 0 && m < 12) begin
      @(negedge clk);
      if (++m == 1) chk(cr, pol);
    end
  endtask
  task automatic t_pulse;
    int m;
    pulse(8'h01, m);
    chk(n >= 4 && n < 12, 1);
    chk(m, 3);
    pulse(8'h01, m);
    chk(n, 12);
    pol = 1;
    pulse(8'h00, m);
    pulse(8'h01, m);
    chk(m, 3);
    {pol, kr_b} = 0;
    repeat (2) @(negedge clk);
    chk(cr, 0);
    kr_b = 1;
  endtask
  task automatic t_p17;
    {od, p17} = 2'h2;
    repeat (3) @(negedge clk);
    chk({po, pe_b}, 0);
    p17 = 1;
    repeat (2) @(negedge clk);
    chk(pe_b, 1);
    {od, p17} = 0;
    repeat (3) @(negedge clk);
    p17 = 1;
    repeat (2) @(negedge clk);
    chk({po, pe_b}, 8'h02);
    repeat (8) @(negedge clk);
    chk(pe_b, 1);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1;
    host.io(0, 16'h0092, 8'h00, q, e);
    chk(q, 8'h24);
    chk(e, 1);
    chk({gl, pn_b, cr}, 8'h03);
    t_gate;
    t_pulse;
    // every other config bit set, so only the enable bit is off
    cfg = 8'hFB;
    host.io(1, 16'h0092, 8'h02, q, e);
    host.io(0, 16'h0092, 8'h00, q, e);
    chk({e, gl}, 0);
    t_p17;
    finish_test;
  end
endmodule
`default_nettype wire

/* test/fast_gate_assertions.sv */
// checker for the fast gate port
`timescale 1ns/10ps
`default_nettype none
module fast_gate_chk #(parameter int WIDTH_CYC = 3) (
  input wire logic i_clk_sys, i_rst_b, i_io_wr, i_io_rd,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata, o_io_rdata, i_kbd_reset_gate_cfg,
  input wire logic o_io_rdata_oe, i_reset_polarity, i_kbc_gate_port_bit,
  input wire logic i_kbc_reset_n, o_alternate_gate_line,
  input wire logic o_fast_reset_pulse_n, o_addr20_mask_out_n,
  input wire logic o_cpu_reset_out);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  wire hit = i_io_addr == 16'h0092 && i_kbd_reset_gate_cfg[2];
  wire gl = o_alternate_gate_line;
  wire pn = o_fast_reset_pulse_n;
  // counts low cycles so long pulses need no long delay in a property
  int low_cnt;
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) low_cnt <= 0;
    else if (!pn) low_cnt <= low_cnt + 1;
    else low_cnt <= 0;
  end
  rst_vals_a: assert property ($rose(i_rst_b) |-> !gl && pn && o_cpu_reset_out)
    else $error("bad values after reset");
  rd_ans_a: assert property (i_io_rd && hit |=> o_io_rdata_oe
    && o_io_rdata[7:2] == 6'h09) else $error("bad read answer");
  rd_off_a: assert property (i_io_rd && !hit |=> !o_io_rdata_oe)
    else $error("refused read drove bus");
  gate_wr_a: assert property (i_io_wr && hit |=> gl == $past(i_io_wdata[1]))
    else $error("gate line not written");
  wr_off_a: assert property (i_io_wr && !hit |=> $stable(gl))
    else $error("refused write changed gate");
  // only checked once both sources have settled, as the mask lags a cycle
  mask_or_a: assert property ($past(i_rst_b) && $stable(gl)
    && $stable(i_kbc_gate_port_bit)
    |-> o_addr20_mask_out_n == (gl | i_kbc_gate_port_bit)) else $error("bad mask");
  pulse_w_a: assert property ($rose(pn) |-> low_cnt == WIDTH_CYC)
    else $error("bad pulse width");
  cpu_rst_a: assert property ($past(i_rst_b) && $past(i_kbd_reset_gate_cfg[2])
    |-> o_cpu_reset_out == (($past(pn) & $past(i_kbc_reset_n))
    ^ $past(i_reset_polarity))) else $error("bad cpu reset");
endmodule
bind fast_gate_a20_and_cpu_reset fast_gate_chk #(.WIDTH_CYC(WIDTH_CYC)) chk_i (.*);
`default_nettype wire

/* test/isa_host_model.sv */
// host i/o master for the fast gate port
`timescale 1ns/10ps
`default_nettype none
module isa_host_model (
  input wire logic i_clk_sys, i_oe,
  input wire logic [7:0] i_rdata,
  output logic [15:0] o_addr,
  output logic o_wr, o_rd,
  output logic [7:0] o_wdata);
  initial {o_addr, o_wr, o_rd, o_wdata} = 26'h0;
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    @(negedge i_clk_sys);
    {o_addr, o_wdata, o_wr, o_rd} = {a, d, w, !w};
    @(negedge i_clk_sys);
    // released lines show garbage, never the last value
    {o_addr, o_wdata, o_wr, o_rd} = {~a, ~d, 2'h0};
    {q, e} = {i_rdata, i_oe};
  endtask
endmodule
`default_nettype wire
